// [hdl/phy_rx_defines.svh]
// register map, reset values, code groups and timing counts of the receive block
`ifndef PHY_RX_DEFINES_SVH
`define PHY_RX_DEFINES_SVH
`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004
`define EDCFG_OFS 12'h008
`define FCC_OFS 12'h014
`define CTRL_RST 4'h1
`define EDCFG_RST 32'h0100_2040
`define CG_IDLE 5'h1F
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0D
`define CG_R 5'h07
`define PRE_NIB 4'h5
`define BAD_NIB 4'hE
`define CLK_NS 4
`define SQ_MIN_NS 50
`define SQ_MIN_CYC ((`SQ_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define SQ_MAX_NS 200
`define SQ_MAX_CYC (`SQ_MAX_NS / `CLK_NS)
`define SQ_QUIET_NS 300
`define SQ_QUIET_CYC (`SQ_QUIET_NS / `CLK_NS)
`define SQ_TR_RX 3'h2
`define SQ_TR_TX 3'h5
`define JAB_MS 100
`define UNJAB_MS 500
`define NS_PER_MS 1000000
`define LM_RECOV_NS 10000
`define LM_RECOV_CYC (`LM_RECOV_NS / `CLK_NS)
`define LOCK_RUN 6'h3C
`define IDLE_RUN 4'hA
`endif

// [hdl/phy_rx_pkg.sv]
// types shared by the receive block
package phy_rx_pkg;
  typedef struct packed {
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
    logic col;
    logic rx_stb;
  } mii_rx_t;
  typedef struct packed {
    logic lm_scrf;
    logic lm_recov;
    logic full;
    logic speed100;
  } ctrl_t;
  typedef struct packed {
    logic [15:0] period;
    logic [7:0] off_thr;
    logic [7:0] on_thr;
  } edcfg_t;
  typedef enum logic [3:0] {G_IDLE = 4'b0001, G_SSD = 4'b0010,
    G_DATA = 4'b0100, G_BAD = 4'b1000} grp_st_t;
  typedef enum logic [2:0] {SQ_IDLE = 3'b001, SQ_ARM = 3'b010,
    SQ_VALID = 3'b100} sq_st_t;
  typedef enum logic [3:0] {LM_DOWN = 4'b0001, LM_UP = 4'b0010,
    LM_RECOV = 4'b0100, LM_FAIL = 4'b1000} lm_st_t;
endpackage : phy_rx_pkg

// [hdl/phy_rx_top.sv]
// receive decode, squelch, carrier, jabber and link monitor logic
`timescale 1ns/1ps
`default_nettype none
`include "phy_rx_defines.svh"
module phy_rx_top #(
  parameter int unsigned JAB_CYC = `JAB_MS * `NS_PER_MS / `CLK_NS,
  parameter int unsigned UNJAB_CYC = `UNJAB_MS * `NS_PER_MS / `CLK_NS,
  parameter int unsigned SYNC_BITS = 20000
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bclk,
  input wire logic rx_bit,
  input wire logic ten_clk,
  input wire logic ten_bit,
  input wire logic sq_pos,
  input wire logic sq_neg,
  input wire logic tx_en,
  input wire logic [7:0] ed_sample,
  output var phy_rx_pkg::mii_rx_t mii_rx,
  output var logic tx_drv_en,
  output logic sig_det,
  output logic link_up,
  output var logic link_restart
);
  import phy_rx_pkg::*;

  function automatic logic [4:0] dec5(input logic [4:0] cg);
    case (cg)
      5'h1E: dec5 = 5'h10;
      5'h09: dec5 = 5'h11;
      5'h14: dec5 = 5'h12;
      5'h15: dec5 = 5'h13;
      5'h0A: dec5 = 5'h14;
      5'h0B: dec5 = 5'h15;
      5'h0E: dec5 = 5'h16;
      5'h0F: dec5 = 5'h17;
      5'h12: dec5 = 5'h18;
      5'h13: dec5 = 5'h19;
      5'h16: dec5 = 5'h1A;
      5'h17: dec5 = 5'h1B;
      5'h1A: dec5 = 5'h1C;
      5'h1B: dec5 = 5'h1D;
      5'h1C: dec5 = 5'h1E;
      5'h1D: dec5 = 5'h1F;
      default: dec5 = {1'b0, `BAD_NIB};
    endcase
  endfunction : dec5

  ctrl_t ctrl_reg;
  edcfg_t edcfg_reg;
  logic [6:0] s1_reg, s2_reg, s3_reg;
  logic b_stb, rbit, t_stb, tbit, pos_r, neg_r, txen;
  logic [10:0] lfsr_reg;
  logic locked_reg;
  logic [5:0] lrun_reg;
  logic [3:0] ones_reg;
  logic [15:0] since_reg;
  logic key, dbit;
  grp_st_t gs_reg;
  logic [9:0] sr_reg, sr_next;
  logic [4:0] grp, dg;
  logic [2:0] ph_reg, wcnt_reg;
  logic idl_reg, tp_reg, p2_reg;
  logic [3:0] p2n_reg;
  logic [1:0] fcinc_reg;
  mii_rx_t m100_reg;
  logic [15:0] fcc_reg;
  logic [16:0] fcc_sum;
  sq_st_t sq_reg;
  logic [7:0] tmr_reg;
  logic [2:0] ntr_reg, need;
  logic lastp_reg, opp, rx10;
  logic al_reg, prev_reg, r10dv_reg, r10stb_reg;
  logic [3:0] nib_reg, r10d_reg;
  logic [1:0] nc_reg;
  logic [26:0] jcnt_reg;
  logic jab_reg;
  lm_st_t lm_reg;
  logic [11:0] rtmr_reg;
  logic [10:0] acc_reg;
  logic [15:0] per_reg;
  logic sig_det_reg;
  logic pslverr_reg;
  logic [7:0] status;

  // pins from the line and the mac: two flops, third only for edges
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      s1_reg <= 7'h00;
      s2_reg <= 7'h00;
      s3_reg <= 7'h00;
    end
    else
    begin
      s1_reg <= {rx_bclk, rx_bit, ten_clk, ten_bit, sq_pos, sq_neg, tx_en};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end

  // link data is taken on the sampled rising link clock edge
  assign b_stb = s2_reg[6] & ~s3_reg[6];
  assign rbit = s2_reg[5];
  assign t_stb = s2_reg[4] & ~s3_reg[4];
  assign tbit = s2_reg[3];
  assign pos_r = s2_reg[2] & ~s3_reg[2];
  assign neg_r = s2_reg[1] & ~s3_reg[1];
  assign txen = s2_reg[0];

  assign key = lfsr_reg[10] ^ lfsr_reg[8];
  assign dbit = rbit ^ key;

  // descrambler: idle is all ones, so inverted line bits seed the lfsr
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      lfsr_reg <= 11'h000;
      locked_reg <= 1'b0;
      lrun_reg <= 6'h00;
      ones_reg <= 4'h0;
      since_reg <= 16'h0000;
    end
    else if (b_stb)
    begin
      if (!locked_reg)
      begin
        lfsr_reg <= {lfsr_reg[9:0], ~rbit};
        ones_reg <= 4'h0;
        since_reg <= 16'h0000;
        if (rbit == key)
          lrun_reg <= 6'h00;
        else if (lrun_reg == `LOCK_RUN - 6'h01)
        begin
          locked_reg <= 1'b1;
          lrun_reg <= 6'h00;
        end
        else
          lrun_reg <= lrun_reg + 6'h01;
      end
      else
      begin
        lfsr_reg <= {lfsr_reg[9:0], key};
        if (!dbit)
          ones_reg <= 4'h0;
        else if (ones_reg != `IDLE_RUN)
          ones_reg <= ones_reg + 4'h1;
        // a long stretch without any idle run means sync is gone
        if (ones_reg == `IDLE_RUN)
          since_reg <= 16'h0000;
        else if (since_reg == 16'(SYNC_BITS - 1))
          locked_reg <= 1'b0;
        else
          since_reg <= since_reg + 16'h0001;
      end
    end

  assign sr_next = {sr_reg[8:0], dbit};
  assign grp = sr_next[4:0];
  assign dg = dec5(grp);

  // code-group framing and nibble delivery at 100M
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      gs_reg <= G_IDLE;
      sr_reg <= 10'h3FF;
      ph_reg <= 3'h0;
      wcnt_reg <= 3'h0;
      idl_reg <= 1'b0;
      tp_reg <= 1'b0;
      p2_reg <= 1'b0;
      p2n_reg <= 4'h0;
      fcinc_reg <= 2'h0;
      m100_reg <= '0;
    end
    else
    begin
      m100_reg.rx_stb <= 1'b0;
      fcinc_reg <= 2'h0;
      if (p2_reg)
      begin
        m100_reg.rxd <= p2n_reg;
        m100_reg.rx_stb <= 1'b1;
        p2_reg <= 1'b0;
      end
      if (b_stb && !locked_reg)
      begin
        gs_reg <= G_IDLE;
        m100_reg.rx_dv <= 1'b0;
        m100_reg.rx_er <= 1'b0;
        m100_reg.crs <= 1'b0;
      end
      else if (b_stb)
      begin
        sr_reg <= sr_next;
        case (gs_reg)
          G_IDLE:
            if (!dbit)
            begin
              gs_reg <= G_SSD;
              wcnt_reg <= 3'h0;
              m100_reg.crs <= 1'b1;
            end
          G_SSD:
            // first zero sits at the third bit of the first group
            if (wcnt_reg == 3'h6)
            begin
              ph_reg <= 3'h0;
              idl_reg <= 1'b0;
              tp_reg <= 1'b0;
              p2_reg <= 1'b1;
              m100_reg.rx_stb <= 1'b1;
              if (sr_next == {`CG_J, `CG_K})
              begin
                gs_reg <= G_DATA;
                m100_reg.rxd <= `PRE_NIB;
                p2n_reg <= `PRE_NIB;
                m100_reg.rx_dv <= 1'b1;
                m100_reg.rx_er <= 1'b0;
              end
              else
              begin
                gs_reg <= G_BAD;
                m100_reg.rxd <= `BAD_NIB;
                p2n_reg <= `BAD_NIB;
                m100_reg.rx_er <= 1'b1;
                fcinc_reg <= 2'h2;
              end
            end
            else
              wcnt_reg <= wcnt_reg + 3'h1;
          G_DATA, G_BAD:
            if (ph_reg != 3'h4)
              ph_reg <= ph_reg + 3'h1;
            else
            begin
              ph_reg <= 3'h0;
              if (grp == `CG_IDLE && idl_reg)
              begin
                gs_reg <= G_IDLE;
                m100_reg.rx_dv <= 1'b0;
                m100_reg.rx_er <= 1'b0;
                m100_reg.crs <= 1'b0;
                tp_reg <= 1'b0;
              end
              else if (gs_reg == G_BAD)
              begin
                idl_reg <= (grp == `CG_IDLE);
                m100_reg.rxd <= `BAD_NIB;
                m100_reg.rx_er <= 1'b1;
                m100_reg.rx_stb <= 1'b1;
                fcinc_reg <= 2'h1;
              end
              else if (tp_reg && grp == `CG_R)
              begin
                gs_reg <= G_IDLE;
                m100_reg.rx_dv <= 1'b0;
                m100_reg.rx_er <= 1'b0;
                m100_reg.crs <= 1'b0;
                tp_reg <= 1'b0;
              end
              else if (!tp_reg && grp == `CG_T)
              begin
                tp_reg <= 1'b1; // held back until its partner shows
                idl_reg <= 1'b0;
              end
              else
              begin
                // data groups, lone T or R, control groups and invalid codes
                idl_reg <= (grp == `CG_IDLE);
                tp_reg <= 1'b0;
                m100_reg.rx_stb <= 1'b1;
                m100_reg.rxd <= tp_reg ? `BAD_NIB : dg[3:0];
                m100_reg.rx_er <= tp_reg | ~dg[4];
              end
            end
          default:
            gs_reg <= G_IDLE;
        endcase
      end
    end

  // false carrier count saturates rather than wrapping
  assign fcc_sum = {1'b0, fcc_reg} + {15'h0000, fcinc_reg};
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      fcc_reg <= 16'h0000;
    else if (fcinc_reg != 2'h0)
      fcc_reg <= fcc_sum[16] ? 16'hFFFF : fcc_sum[15:0];

  // squelch qualification on the 10M comparator levels
  assign need = txen ? `SQ_TR_TX : `SQ_TR_RX;
  assign opp = lastp_reg ? neg_r : pos_r;
  assign rx10 = (sq_reg == SQ_VALID);
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      sq_reg <= SQ_IDLE;
      tmr_reg <= 8'h00;
      ntr_reg <= 3'h0;
      lastp_reg <= 1'b0;
    end
    else
      case (sq_reg)
        SQ_IDLE:
        begin
          tmr_reg <= 8'h00;
          ntr_reg <= 3'h0;
          if (pos_r | neg_r)
          begin
            sq_reg <= SQ_ARM;
            lastp_reg <= pos_r;
          end
        end
        SQ_ARM:
        begin
          tmr_reg <= tmr_reg + 8'h01;
          if (opp)
          begin
            tmr_reg <= 8'h00;
            if (tmr_reg < 8'(`SQ_MIN_CYC))
              sq_reg <= SQ_IDLE;
            else if (ntr_reg + 3'h1 == need)
            begin
              sq_reg <= SQ_VALID;
              ntr_reg <= 3'h0;
            end
            else
            begin
              ntr_reg <= ntr_reg + 3'h1;
              lastp_reg <= ~lastp_reg;
            end
          end
          else if (tmr_reg == 8'(`SQ_MAX_CYC))
            sq_reg <= SQ_IDLE;
        end
        SQ_VALID:
          if (pos_r | neg_r)
            tmr_reg <= 8'h00;
          else if (tmr_reg == 8'(`SQ_QUIET_CYC))
            sq_reg <= SQ_IDLE;
          else
            tmr_reg <= tmr_reg + 8'h01;
        default:
          sq_reg <= SQ_IDLE;
      endcase

  // 10M nibbles: the recovered bit clock is followed edge by edge, so
  // jitter and rate offset are absorbed by the 250 MHz sampling
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      al_reg <= 1'b0;
      prev_reg <= 1'b0;
      nib_reg <= 4'h0;
      nc_reg <= 2'h0;
      r10d_reg <= 4'h0;
      r10dv_reg <= 1'b0;
      r10stb_reg <= 1'b0;
    end
    else
    begin
      r10stb_reg <= 1'b0;
      if (!rx10)
      begin
        al_reg <= 1'b0;
        prev_reg <= 1'b0;
        r10dv_reg <= 1'b0;
      end
      else if (t_stb)
      begin
        if (!al_reg)
        begin
          prev_reg <= tbit;
          if (prev_reg & tbit)
          begin
            al_reg <= 1'b1;
            nc_reg <= 2'h0;
          end
        end
        else
        begin
          nib_reg <= {tbit, nib_reg[3:1]};
          nc_reg <= nc_reg + 2'h1;
          if (nc_reg == 2'h3)
          begin
            r10d_reg <= {tbit, nib_reg[3:1]};
            r10dv_reg <= 1'b1;
            r10stb_reg <= 1'b1;
          end
        end
      end
    end

  // jabber guards the 10M transmitter only
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      jcnt_reg <= 27'h0000000;
      jab_reg <= 1'b0;
    end
    else if (ctrl_reg.speed100)
    begin
      jcnt_reg <= 27'h0000000;
      jab_reg <= 1'b0;
    end
    else if (!jab_reg)
    begin
      if (!txen)
        jcnt_reg <= 27'h0000000;
      else if (jcnt_reg == 27'(JAB_CYC - 1))
      begin
        jab_reg <= 1'b1;
        jcnt_reg <= 27'h0000000;
      end
      else
        jcnt_reg <= jcnt_reg + 27'h0000001;
    end
    else if (txen)
      jcnt_reg <= 27'h0000000;
    else if (jcnt_reg == 27'(UNJAB_CYC - 1))
    begin
      jab_reg <= 1'b0;
      jcnt_reg <= 27'h0000000;
    end
    else
      jcnt_reg <= jcnt_reg + 27'h0000001;

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      tx_drv_en <= 1'b0;
    else if (ctrl_reg.speed100)
      tx_drv_en <= txen & locked_reg;
    else
      tx_drv_en <= txen & ~jab_reg;

  // energy detect: iir level, decided once per listening period
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      acc_reg <= 11'h000;
      per_reg <= 16'h0000;
      sig_det_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_reg - {3'h0, acc_reg[10:3]} + {3'h0, ed_sample};
      if (per_reg < edcfg_reg.period)
        per_reg <= per_reg + 16'h0001;
      else
      begin
        per_reg <= 16'h0000;
        // two thresholds keep the indication from chattering
        if (!sig_det_reg && acc_reg[10:3] >= edcfg_reg.on_thr)
          sig_det_reg <= 1'b1;
        else if (sig_det_reg && acc_reg[10:3] < edcfg_reg.off_thr)
          sig_det_reg <= 1'b0;
      end
    end
  assign sig_det = sig_det_reg;

  // link monitor with the two optional add-ons
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      lm_reg <= LM_DOWN;
      rtmr_reg <= 12'h000;
      link_restart <= 1'b0;
    end
    else
    begin
      link_restart <= 1'b0;
      case (lm_reg)
        LM_DOWN:
          if (sig_det_reg && locked_reg)
            lm_reg <= LM_UP;
        LM_UP:
          if (ctrl_reg.lm_scrf && !locked_reg)
            lm_reg <= LM_DOWN;
          else if (!sig_det_reg && ctrl_reg.lm_recov)
          begin
            lm_reg <= LM_RECOV;
            rtmr_reg <= 12'h000;
          end
          else if (!sig_det_reg)
            lm_reg <= LM_FAIL;
        LM_RECOV:
          if (sig_det_reg)
            lm_reg <= LM_UP;
          else if (rtmr_reg == 12'(`LM_RECOV_CYC - 1))
            lm_reg <= LM_FAIL;
          else
            rtmr_reg <= rtmr_reg + 12'h001;
        LM_FAIL:
        begin
          link_restart <= 1'b1;
          lm_reg <= LM_DOWN;
        end
        default:
          lm_reg <= LM_DOWN;
      endcase
    end
  assign link_up = lm_reg[1];

  // mii receive outputs for the selected speed
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      mii_rx <= '0;
    else if (ctrl_reg.speed100)
      mii_rx <= {m100_reg.rxd, m100_reg.rx_dv, m100_reg.rx_er,
                 m100_reg.crs, 1'b0, m100_reg.rx_stb};
    else
      mii_rx <= {r10d_reg, r10dv_reg & rx10, 1'b0,
                 rx10 | (~ctrl_reg.full & txen),
                 ~ctrl_reg.full & rx10 & txen,
                 r10stb_reg};

  // apb slave: zero wait, read data loaded in the setup cycle
  assign status = {lm_reg, jab_reg, rx10, sig_det_reg, locked_reg};
  assign pready = 1'b1;
  assign pslverr = pslverr_reg & psel & penable;
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      ctrl_reg <= `CTRL_RST;
      edcfg_reg <= `EDCFG_RST;
      prdata <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr_reg <= 1'b0;
      case (paddr)
        `CTRL_OFS: prdata <= {28'h0000000, ctrl_reg};
        `STAT_OFS: prdata <= {24'h000000, status};
        `EDCFG_OFS: prdata <= edcfg_reg;
        `FCC_OFS: prdata <= {16'h0000, fcc_reg};
        default:
        begin
          prdata <= 32'h00000000;
          pslverr_reg <= 1'b1;
        end
      endcase
    end
    else if (psel && penable && pwrite)
      case (paddr)
        `CTRL_OFS: ctrl_reg <= pwdata[3:0];
        `EDCFG_OFS: edcfg_reg <= pwdata;
        default: ;
      endcase
endmodule : phy_rx_top
`default_nettype wire

// [tb/phy_rx_top_monitor.sv]
// port-level assertion checker for the receive block
`timescale 1ns/1ps
`default_nettype none
module phy_rx_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_en,
  input wire phy_rx_pkg::mii_rx_t mii_rx,
  input wire logic tx_drv_en
);
  import phy_rx_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray slave error");
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_rd0; psel && penable && pslverr && !pwrite |-> prdata == 0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped data");
  property p_bad; mii_rx.rx_stb && mii_rx.rx_er |-> mii_rx.rxd == 4'hE;
  endproperty
  a_bad: assert property (p_bad) else $error("error nibble");
  property p_dv; $rose(mii_rx.rx_dv) |-> mii_rx.rx_stb; endproperty
  a_dv: assert property (p_dv) else $error("valid w/o nibble");
  property p_stb; mii_rx.rx_stb |-> mii_rx.crs; endproperty
  a_stb: assert property (p_stb) else $error("nibble w/o carrier");
  property p_col; mii_rx.col |-> mii_rx.crs; endproperty
  a_col: assert property (p_col) else $error("col w/o carrier");
  property p_drv; !tx_en [*4] |=> !tx_drv_en; endproperty
  a_drv: assert property (p_drv) else $error("drive w/o enable");
  property p_end; $fell(mii_rx.crs) |-> !mii_rx.rx_er && !mii_rx.rx_dv;
  endproperty
  a_end: assert property (p_end) else $error("error past carrier");
endmodule : phy_rx_monitor
bind phy_rx_top phy_rx_monitor phy_rx_monitor_i (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .tx_en(tx_en),
  .mii_rx(mii_rx),
  .tx_drv_en(tx_drv_en)
);
`default_nettype wire

// [tb/phy_line_model.sv]
// far-end scrambling transmitter on the 100M line
`timescale 1ns/1ps
`default_nettype none
module phy_line_model (
  output logic rx_bclk,
  output logic rx_bit
);
  logic [10:0] scr;
  logic [4:0] q[$];
  logic [4:0] g;
  logic key;
  task automatic send(input logic [4:0] c);
    q.push_back(c);
  endtask : send
  // line clock runs free: the descrambler needs idle to hold lock
  initial
  begin
    rx_bclk = 1'b0;
    rx_bit = 1'b0;
    scr = 11'h5A5;
    #1;
    forever
    begin
      g = (q.size() != 0) ? q.pop_front() : 5'h1F;
      for (int i = 4; i >= 0; i--)
      begin
        key = scr[10] ^ scr[8];
        scr = {scr[9:0], key};
        rx_bclk = 1'b0;
        rx_bit = g[i] ^ key;
        #32;
        rx_bclk = 1'b1;
        #32;
      end
    end
  end
endmodule : phy_line_model
`default_nettype wire

// [tb/tb_phy_rx_top.sv]
// self-checking bench for the receive block
`timescale 1ns/1ps
`default_nettype none
`include "phy_rx_defines.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
  end end
module tb_phy_rx_top;
  import phy_rx_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sq_pos = 1'b0, sq_neg = 1'b0, tx_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q = 32'h0, c0;
  logic pready, pslverr, err, rx_bclk, rx_bit;
  logic tx_drv_en, sig_det, link_up, link_restart;
  logic ten_clk = 1'b0, ten_bit = 1'b0;
  logic [7:0] ed = 8'h00;
  mii_rx_t mii_rx;
  logic [3:0] nibs[$];
  int fail_count = 0, checks_done = 0, restarts = 0;
  always #2 core_clk = ~core_clk;
  phy_rx_top #(.JAB_CYC(200), .UNJAB_CYC(500), .SYNC_BITS(200))
  phy_rx_top_i (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bclk(rx_bclk), .rx_bit(rx_bit), .ten_clk(ten_clk),
    .ten_bit(ten_bit), .sq_pos(sq_pos), .sq_neg(sq_neg), .tx_en(tx_en),
    .ed_sample(ed),
    .mii_rx(mii_rx), .tx_drv_en(tx_drv_en), .sig_det(sig_det),
    .link_up(link_up), .link_restart(link_restart));
  phy_line_model phy_line_model_i (.rx_bclk(rx_bclk), .rx_bit(rx_bit));
  always @(posedge core_clk)
  begin
    if (mii_rx.rx_stb === 1'b1)
      nibs.push_back(mii_rx.rxd);
    if (link_restart === 1'b1)
      restarts++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_crs(input logic v);
    for (int n = 0; n < 3000 && mii_rx.crs !== v; n++)
      @(posedge core_clk);
  endtask : wait_crs
  // send a frame, wait for carrier to come and go
  task automatic run(input logic [4:0] gs[$]);
    nibs.delete();
    foreach (gs[i])
      phy_line_model_i.send(gs[i]);
    wait_crs(1'b1);
    wait_crs(1'b0);
    cyc(5);
  endtask : run
  task automatic cmp(input logic [3:0] e[$]);
    `CHK("nibble count", e.size(), nibs.size())
    foreach (e[i])
      `CHK("nibble", e[i], nibs[i])
  endtask : cmp
  // rising edges of the chosen comparator level, gap+2 cycles apart
  task automatic pulse(input logic p, input int gap);
    sq_pos <= p;
    sq_neg <= !p;
    cyc(2);
    sq_pos <= 1'b0;
    sq_neg <= 1'b0;
    cyc(gap);
  endtask : pulse
  // 10M bits at 64 ns, b[0] first; level edges keep squelch open
  task automatic ten(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      ten_bit <= b[i];
      cyc(8);
      ten_clk <= 1'b1;
      sq_pos <= 1'b1;
      cyc(8);
      ten_clk <= 1'b0;
      sq_pos <= 1'b0;
    end
  endtask : ten
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial
  begin
    cyc(60000);
    fail_count++;
    final_report();
  end
  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    apb(1'b0, `CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'(`CTRL_RST), q)
    apb(1'b0, `EDCFG_OFS, 32'h0);
    `CHK("edcfg", `EDCFG_RST, q)
    apb(1'b1, `FCC_OFS, 32'h1234);
    apb(1'b0, `FCC_OFS, 32'h0);
    `CHK("count", 32'h0, q)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 1'b1, err)
    tx_en <= 1'b1;
    ed <= 8'h80;
    cyc(10);
    `CHK("drive unlocked", 1'b0, tx_drv_en)
    repeat (1000)
      if (q[0] !== 1'b1)
        apb(1'b0, `STAT_OFS, 32'h0);
    `CHK("locked", 1'b1, q[0])
    `CHK("drive locked", 1'b1, tx_drv_en)
    `CHK("signal", 1'b1, sig_det)
    `CHK("link up", 1'b1, link_up)
    cyc(300);
    `CHK("no jabber at 100M", 1'b1, tx_drv_en)
    tx_en <= 1'b0;
    run('{`CG_J, `CG_K, 5'h15, 5'h16, `CG_T, `CG_R});
    cmp('{`PRE_NIB, `PRE_NIB, 4'h3, 4'hA});
    `CHK("valid off", 1'b0, mii_rx.rx_dv)
    run('{`CG_J, `CG_K, 5'h15, `CG_IDLE, `CG_IDLE});
    cmp('{`PRE_NIB, `PRE_NIB, 4'h3, `BAD_NIB});
    apb(1'b1, `CTRL_OFS, 32'h5);
    ed <= 8'h00;
    run('{`CG_J, `CG_K, `CG_R, `CG_T, 5'h15, `CG_T, `CG_R});
    cmp('{`PRE_NIB, `PRE_NIB, `BAD_NIB, `BAD_NIB});
    `CHK("recovering", 1'b0, link_up)
    ed <= 8'h80;
    apb(1'b0, `FCC_OFS, 32'h0);
    c0 = q;
    run('{5'h1E, 5'h1E, `CG_IDLE, `CG_IDLE});
    `CHK("bad nibbles", 1'b1, nibs.size() >= 2)
    foreach (nibs[i])
      `CHK("bad nibble", `BAD_NIB, nibs[i])
    apb(1'b0, `FCC_OFS, 32'h0);
    `CHK("false carrier", c0 + 32'(nibs.size()), q)
    `CHK("error off", 1'b0, mii_rx.rx_er)
    `CHK("link back", 1'b1, link_up)
    apb(1'b1, `CTRL_OFS, 32'h0);
    ed <= 8'h00;
    pulse(1'b1, 4);
    pulse(1'b0, 4);
    pulse(1'b1, 4);
    `CHK("squelch reject", 1'b0, mii_rx.crs)
    cyc(80);
    pulse(1'b1, 14);
    pulse(1'b0, 14);
    pulse(1'b1, 6);
    `CHK("squelch valid", 1'b1, mii_rx.crs)
    `CHK("no collision", 1'b0, mii_rx.col)
    nibs.delete();
    ten(8'h1B);
    cmp('{4'h6});
    cyc(100);
    `CHK("carrier end", 1'b0, mii_rx.crs)
    tx_en <= 1'b1;
    cyc(6);
    `CHK("carrier on send", 1'b1, mii_rx.crs)
    pulse(1'b1, 14);
    pulse(1'b0, 14);
    pulse(1'b1, 14);
    `CHK("three edges", 1'b0, mii_rx.col)
    pulse(1'b0, 14);
    pulse(1'b1, 14);
    pulse(1'b0, 6);
    `CHK("collision", 1'b1, mii_rx.col)
    cyc(100);
    apb(1'b1, `CTRL_OFS, 32'h2);
    cyc(6);
    `CHK("full duplex send", 1'b0, mii_rx.crs)
    apb(1'b1, `CTRL_OFS, 32'h0);
    cyc(260);
    `CHK("jabbed", 1'b0, tx_drv_en)
    cyc(300);
    `CHK("held off", 1'b0, tx_drv_en)
    tx_en <= 1'b0;
    cyc(560);
    tx_en <= 1'b1;
    cyc(6);
    `CHK("unjabbed", 1'b1, tx_drv_en)
    tx_en <= 1'b0;
    `CHK("link down", 1'b0, link_up)
    `CHK("restarts", 1, restarts)
    final_report();
  end
endmodule : tb_phy_rx_top
`default_nettype wire
